// >>> hw/pesr_defines.vh
// Purpose: Shared constants for the PHY event/status register group.
// Assumes: Clause 22 style management frames, 16-bit registers.
// Notes:   Definitions only; included by bare name.
`ifndef PESR_DEFINES_VH
`define PESR_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define PESR_ADDR_EVENT 5'h1B
`define PESR_ADDR_CABLE 5'h1D
`define PESR_ADDR_LINE 5'h1E

// ----------------------------------------------------------------
// Event register fields
// ----------------------------------------------------------------
`define PESR_EV_EN_HI 15
`define PESR_EV_EN_LO 8
`define PESR_EV_FLAG_HI 7
`define PESR_EV_FLAG_LO 0

// ----------------------------------------------------------------
// Cable test register fields
// ----------------------------------------------------------------
`define PESR_CBL_START 15
`define PESR_CBL_RES_HI 14
`define PESR_CBL_RES_LO 13
`define PESR_CBL_SHORT 12
`define PESR_CBL_RSV_HI 11
`define PESR_CBL_RSV_LO 9
`define PESR_CBL_DIST_HI 8
`define PESR_CBL_DIST_LO 0

// ----------------------------------------------------------------
// Line status register fields
// ----------------------------------------------------------------
`define PESR_LN_FLOW 9
`define PESR_LN_LINK 8
`define PESR_LN_POL 7
`define PESR_LN_MDIX 5
`define PESR_LN_ENERGY 4
`define PESR_LN_ISOLATE 3
`define PESR_LN_MODE_HI 2
`define PESR_LN_MODE_LO 0

// ----------------------------------------------------------------
// Reset values and frame constants
// ----------------------------------------------------------------
`define PESR_RST_BYTE 8'h00
`define PESR_RST_WORD 16'h0000
`define PESR_RST_RSV3 3'h0
`define PESR_RST_RES2 2'h0
`define PESR_RST_DIST 9'h000
`define PESR_PRE_ONES 6'h20
`define PESR_HDR_BITS 5'h0D
`define PESR_DATA_BITS 5'h10
`define PESR_TA_BITS 5'h02
`define PESR_OP_READ 2'h2
`define PESR_OP_WRITE 2'h1

`endif

// >>> hw/pesr_mgmt_slave.v
// Purpose: Management serial slave; decodes frames into register strobes.
// Assumes: mdc and mdio_i are synchronous to clk and much slower than clk.
// Notes:   Outputs change just after an mdc rising edge; master samples next rise.
`timescale 1ns/1ps
`include "pesr_defines.vh"

module pesr_mgmt_slave (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Management pins
    input wire mdc,
    input wire mdio_i,
    output reg mdio_o,
    output reg mdio_oe,
    input wire [4:0] phy_addr,
    // Register side
    output wire [4:0] reg_addr,
    output wire rd_stb,
    input wire [15:0] rd_data,
    output wire wr_stb,
    output wire [15:0] wr_data
);

    // ------------------------------------------------------------
    // Frame states
    // ------------------------------------------------------------
    localparam [1:0] ST_PRE = 2'b00;
    localparam [1:0] ST_HDR = 2'b01;
    localparam [1:0] ST_TA = 2'b10;
    localparam [1:0] ST_DAT = 2'b11;

    reg mdc_q;
    reg [1:0] state_q;
    reg [5:0] ones_q;
    reg [4:0] cnt_q;
    reg [12:0] hdr_q;
    reg [15:0] sh_q;
    reg is_rd_q;
    reg wr_go_q;
    wire rise;
    wire [12:0] hdr_nx;
    wire hit;

    // Rising edge of the management clock
    assign rise = mdc & ~mdc_q;
    assign hdr_nx = {hdr_q[11:0], mdio_i};
    // Start bit, then phy address must match; bits: st1 op2 phy5 reg5
    assign hit = hdr_nx[12] && (hdr_nx[9:5] == phy_addr) &&
                 ((hdr_nx[11:10] == `PESR_OP_READ) || (hdr_nx[11:10] == `PESR_OP_WRITE));
    assign reg_addr = hdr_q[4:0];
    // Read strobe on the first turnaround rise, the same edge that latches the word
    assign rd_stb = rise && (state_q == ST_TA) && (cnt_q == 5'h00) && is_rd_q;
    assign wr_stb = wr_go_q;
    assign wr_data = sh_q;

    // Frame sequencer; a broken frame falls back to preamble hunting
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mdc_q <= 1'b0;
            state_q <= ST_PRE;
            ones_q <= 6'h00;
            cnt_q <= 5'h00;
            hdr_q <= 13'h0000;
            sh_q <= `PESR_RST_WORD;
            is_rd_q <= 1'b0;
            wr_go_q <= 1'b0;
            mdio_o <= 1'b0;
            mdio_oe <= 1'b0;
        end else begin
            mdc_q <= mdc;
            wr_go_q <= 1'b0;
            if (rise) begin
                case (state_q)
                    ST_PRE: begin
                        if (mdio_i) begin
                            if (ones_q != `PESR_PRE_ONES)
                                ones_q <= ones_q + 6'h01;
                        end else if (ones_q == `PESR_PRE_ONES) begin
                            state_q <= ST_HDR;
                            cnt_q <= 5'h00;
                            ones_q <= 6'h00;
                        end else begin
                            ones_q <= 6'h00;
                        end
                    end
                    ST_HDR: begin
                        hdr_q <= hdr_nx;
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == `PESR_HDR_BITS - 5'h01) begin
                            cnt_q <= 5'h00;
                            is_rd_q <= (hdr_nx[11:10] == `PESR_OP_READ);
                            state_q <= hit ? ST_TA : ST_PRE;
                        end
                    end
                    ST_TA: begin
                        cnt_q <= cnt_q + 5'h01;
                        if (is_rd_q && cnt_q == 5'h00) begin
                            // Register value latched here, before any clear-on-read
                            sh_q <= rd_data;
                            mdio_o <= 1'b0;
                            mdio_oe <= 1'b1;
                        end
                        if (cnt_q == `PESR_TA_BITS - 5'h01) begin
                            cnt_q <= 5'h00;
                            state_q <= ST_DAT;
                            if (is_rd_q) begin
                                mdio_o <= sh_q[15];
                                sh_q <= {sh_q[14:0], 1'b0};
                            end
                        end
                    end
                    ST_DAT: begin
                        cnt_q <= cnt_q + 5'h01;
                        if (is_rd_q) begin
                            mdio_o <= sh_q[15];
                            sh_q <= {sh_q[14:0], 1'b0};
                        end else begin
                            sh_q <= {sh_q[14:0], mdio_i};
                        end
                        if (cnt_q == `PESR_DATA_BITS - 5'h01) begin
                            cnt_q <= 5'h00;
                            state_q <= ST_PRE;
                            mdio_oe <= 1'b0;
                            mdio_o <= 1'b0;
                            wr_go_q <= ~is_rd_q;
                        end
                    end
                    default: state_q <= ST_PRE;
                endcase
            end
        end
    end

endmodule // pesr_mgmt_slave

// >>> hw/pesr_event_status.v
// Purpose: Event, cable test and line status registers of a 10/100 PHY.
// Assumes: Event inputs are one-cycle pulses; status inputs are levels.
// Notes:   Cable measurement lives elsewhere; this block starts and records it.
`timescale 1ns/1ps
`include "pesr_defines.vh"

module pesr_event_status (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Management pins
    input wire mdc,
    input wire mdio_i,
    output wire mdio_o,
    output wire mdio_oe,
    input wire [4:0] phy_addr,
    // Event pulses, bit 7 jabber down to bit 0 link-up
    input wire [7:0] event_pulse,
    // Interrupt pin and its polarity control
    input wire int_active_high,
    output reg int_pin,
    // Cable test engine
    output reg cable_test_start,
    input wire cable_test_done,
    input wire [1:0] cable_test_result,
    input wire cable_test_short,
    input wire [8:0] cable_fault_dist,
    // Line status
    input wire flow_ctl_capable,
    input wire link_is_up,
    input wire polarity_reversed,
    input wire mdix_state,
    input wire energy_present,
    input wire [2:0] op_mode,
    output wire isolate
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    reg [7:0] ev_en_q;
    reg [7:0] ev_flag_q;
    reg [7:0] ev_flag_d;
    reg cbl_busy_q;
    reg [1:0] cbl_res_q;
    reg cbl_short_q;
    reg [2:0] cbl_rsv_q;
    reg [8:0] cbl_dist_q;
    reg isolate_q;
    reg [15:0] rd_mux;
    wire [4:0] reg_addr;
    wire rd_stb;
    wire wr_stb;
    wire [15:0] wr_data;
    wire irq_any;
    wire sel_event;
    wire sel_cable;
    wire sel_line;
    wire clr_flags;
    wire start_req;

    // ------------------------------------------------------------
    // Management frame decoder
    // ------------------------------------------------------------
    pesr_mgmt_slave u_slave (
        .clk(clk),
        .rst_b(rst_b),
        .mdc(mdc),
        .mdio_i(mdio_i),
        .mdio_o(mdio_o),
        .mdio_oe(mdio_oe),
        .phy_addr(phy_addr),
        .reg_addr(reg_addr),
        .rd_stb(rd_stb),
        .rd_data(rd_mux),
        .wr_stb(wr_stb),
        .wr_data(wr_data)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // One compare per register, shared by the read-clear and write paths
    assign sel_event = (reg_addr == `PESR_ADDR_EVENT);
    assign sel_cable = (reg_addr == `PESR_ADDR_CABLE);
    assign sel_line = (reg_addr == `PESR_ADDR_LINE);
    // Slave raises rd_stb only for accepted read frames
    assign clr_flags = rd_stb && sel_event;
    // Start request; one arriving while busy is dropped, not queued
    assign start_req = wr_stb && sel_cable && wr_data[`PESR_CBL_START];

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Unmapped addresses read as zero; reserved line status bits read zero, cable bits 11:9 read back the last write
    always @* begin
        rd_mux = `PESR_RST_WORD;
        case (reg_addr)
            `PESR_ADDR_EVENT: begin
                rd_mux[`PESR_EV_EN_HI:`PESR_EV_EN_LO] = ev_en_q;
                rd_mux[`PESR_EV_FLAG_HI:`PESR_EV_FLAG_LO] = ev_flag_q;
            end
            `PESR_ADDR_CABLE: begin
                rd_mux[`PESR_CBL_START] = cbl_busy_q;
                rd_mux[`PESR_CBL_RES_HI:`PESR_CBL_RES_LO] = cbl_res_q;
                rd_mux[`PESR_CBL_SHORT] = cbl_short_q;
                rd_mux[`PESR_CBL_RSV_HI:`PESR_CBL_RSV_LO] = cbl_rsv_q;
                rd_mux[`PESR_CBL_DIST_HI:`PESR_CBL_DIST_LO] = cbl_dist_q;
            end
            `PESR_ADDR_LINE: begin
                rd_mux[`PESR_LN_FLOW] = flow_ctl_capable;
                rd_mux[`PESR_LN_LINK] = link_is_up;
                rd_mux[`PESR_LN_POL] = polarity_reversed;
                rd_mux[`PESR_LN_MDIX] = mdix_state;
                rd_mux[`PESR_LN_ENERGY] = energy_present;
                rd_mux[`PESR_LN_ISOLATE] = isolate_q;
                rd_mux[`PESR_LN_MODE_HI:`PESR_LN_MODE_LO] = op_mode;
            end
            default: rd_mux = `PESR_RST_WORD;
        endcase
    end

    // ------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------
    // A read clears flags, but a pulse landing in the same cycle survives
    always @* begin
        ev_flag_d = ev_flag_q;
        if (clr_flags)
            ev_flag_d = `PESR_RST_BYTE;
        ev_flag_d = ev_flag_d | event_pulse;
    end

    // Flags never take write data
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_flag_q <= `PESR_RST_BYTE;
        end else begin
            ev_flag_q <= ev_flag_d;
        end
    end

    // ------------------------------------------------------------
    // Writable controls
    // ------------------------------------------------------------
    // Only the upper byte of the event register, isolate and the cable reserved bits 11:9 take writes
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_en_q <= `PESR_RST_BYTE;
            isolate_q <= 1'b0;
            cbl_rsv_q <= `PESR_RST_RSV3;
        end else if (wr_stb) begin
            if (sel_event)
                ev_en_q <= wr_data[`PESR_EV_EN_HI:`PESR_EV_EN_LO];
            if (sel_line)
                isolate_q <= wr_data[`PESR_LN_ISOLATE];
            if (sel_cable)
                cbl_rsv_q <= wr_data[`PESR_CBL_RSV_HI:`PESR_CBL_RSV_LO];
        end
    end

    assign isolate = isolate_q;

    // ------------------------------------------------------------
    // Cable test control
    // ------------------------------------------------------------
    // A test in progress cannot be cancelled; a zero write is ignored.
    // Results latch on completion so software never sees a half update.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cbl_busy_q <= 1'b0;
            cable_test_start <= 1'b0;
            cbl_res_q <= `PESR_RST_RES2;
            cbl_short_q <= 1'b0;
            cbl_dist_q <= `PESR_RST_DIST;
        end else begin
            cable_test_start <= 1'b0;
            if (cbl_busy_q && cable_test_done) begin
                cbl_busy_q <= 1'b0;
                cbl_res_q <= cable_test_result;
                cbl_short_q <= cable_test_short;
                cbl_dist_q <= cable_fault_dist;
            end else if (!cbl_busy_q && start_req) begin
                cbl_busy_q <= 1'b1;
                cable_test_start <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------
    // Level output; follows flags, so irq_any drops the cycle after a clearing read and the pin one cycle later
    assign irq_any = |(ev_flag_q & ev_en_q);

    // Polarity applied at the flop so a polarity change never glitches the pin
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            int_pin <= 1'b1;
        end else begin
            int_pin <= int_active_high ? irq_any : ~irq_any;
        end
    end

endmodule // pesr_event_status

// >>> test/pesr_event_status_assertions.sv
// Purpose: Port-level assertions for the PHY event/status register group.
// Assumes: mdc holds each phase for several clk cycles.
// Notes:   Bound to pesr_event_status below the module.
`timescale 1ns/1ps
module pesr_event_status_chk (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Management pins
    input wire mdc,
    input wire mdio_o,
    input wire mdio_oe,
    // Events and outputs
    input wire [7:0] event_pulse,
    input wire int_active_high,
    input wire int_pin,
    input wire cable_test_start,
    input wire isolate
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    // No mdc rise between two samples, so the pins must hold
    sequence s_mdc_low;
        !mdc ##1 !mdc;
    endsequence
    // Polarity flip with no event in flight that could mask it
    sequence s_pol_flip;
        $changed(int_active_high) && !mdc && event_pulse == 8'h00
            && $past(event_pulse) == 8'h00;
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_rst_vals;
        $rose(rst_b) |-> int_pin && !isolate && !cable_test_start && !mdio_oe;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("outputs off at reset");
    property p_start_pulse;
        $rose(cable_test_start) |=> !cable_test_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start too long");
    // Start and isolate only move on a write, which lands in mdc high
    property p_start_src;
        $rose(cable_test_start) |-> mdc;
    endproperty
    a_start_src: assert property (p_start_src) else $error("start without write");
    property p_iso_src;
        $changed(isolate) |-> mdc;
    endproperty
    a_iso_src: assert property (p_iso_src) else $error("isolate without write");
    property p_ta_zero;
        $rose(mdio_oe) |-> mdc && !mdio_o;
    endproperty
    a_ta_zero: assert property (p_ta_zero) else $error("turnaround not zero");
    property p_hold;
        s_mdc_low |-> $stable(mdio_o) && $stable(mdio_oe);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved with mdc low");
    property p_pol;
        s_pol_flip |-> ##[1:2] $changed(int_pin);
    endproperty
    a_pol: assert property (p_pol) else $error("pin ignored polarity");
    // Pin moves only for an event, a frame or a polarity change
    property p_int_src;
        $changed(int_pin) && $past(rst_b, 2) |-> mdc || $past(mdc)
            || $past(event_pulse) != 8'h00 || $past(event_pulse, 2) != 8'h00
            || $past(int_active_high) != $past(int_active_high, 2);
    endproperty
    a_int_src: assert property (p_int_src) else $error("pin moved unprompted");
endmodule // pesr_event_status_chk

bind pesr_event_status pesr_event_status_chk u_chk (
    .clk(clk), .rst_b(rst_b), .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .event_pulse(event_pulse), .int_active_high(int_active_high), .int_pin(int_pin),
    .cable_test_start(cable_test_start), .isolate(isolate)
);

// >>> test/tb.sv
// Purpose: Self-checking bench for the PHY event/status register group.
// Assumes: Bench drives frames, 8 clk per mdc period, all on clk fall.
// Notes:   Status inputs are levels set directly by the bench.
`timescale 1ns/1ps
`include "pesr_defines.vh"
module tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    reg clk = 1'b0, rst_b = 1'b0, mdc = 1'b0, mdio_drv = 1'b1;
    wire mdio_i, mdio_o, mdio_oe, int_pin, cable_test_start, isolate;
    reg [4:0] phy_addr = 5'h03;
    reg [7:0] event_pulse = 8'h00;
    reg int_active_high = 1'b0, cable_test_done = 1'b0, cable_test_short = 1'b0;
    reg [1:0] cable_test_result = 2'h0;
    reg [8:0] cable_fault_dist = 9'h000;
    reg flow_ctl_capable = 1'b0, link_is_up = 1'b0, polarity_reversed = 1'b0;
    reg mdix_state = 1'b0, energy_present = 1'b0;
    reg [2:0] op_mode = 3'h0;
    reg [15:0] rd;
    integer bad_count = 0, tests_run = 0, starts = 0;

    // Released line floats to its pull-up level
    assign mdio_i = mdio_oe ? mdio_o : mdio_drv;
    initial begin
        forever #2.5 clk = ~clk;
    end
    // Start pulses counted to prove they last one cycle
    always @(posedge clk) begin
        if (cable_test_start === 1'b1) starts = starts + 1;
    end

    pesr_event_status u_dut (
        .clk(clk), .rst_b(rst_b), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
        .mdio_oe(mdio_oe), .phy_addr(phy_addr), .event_pulse(event_pulse),
        .int_active_high(int_active_high), .int_pin(int_pin),
        .cable_test_start(cable_test_start), .cable_test_done(cable_test_done),
        .cable_test_result(cable_test_result), .cable_test_short(cable_test_short),
        .cable_fault_dist(cable_fault_dist), .flow_ctl_capable(flow_ctl_capable),
        .link_is_up(link_is_up), .polarity_reversed(polarity_reversed),
        .mdix_state(mdix_state), .energy_present(energy_present), .op_mode(op_mode),
        .isolate(isolate)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input [15:0] got, input [15:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Whole 64-bit frame; read data taken late in each high phase
    task frame(input [1:0] op, input [4:0] pa, input [4:0] ra, input [15:0] wd);
        reg [63:0] v;
        integer k;
        v = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
        for (k = 63; k >= 0; k = k - 1) begin
            mdc = 1'b0;
            mdio_drv = v[k];
            repeat (4) @(negedge clk);
            mdc = 1'b1;
            repeat (4) @(negedge clk);
            if (k >= 1 && k <= 16) rd[k - 1] = mdio_i;
        end
        mdc = 1'b0;
        mdio_drv = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    task wr(input [4:0] ra, input [15:0] d);
        frame(`PESR_OP_WRITE, phy_addr, ra, d);
    endtask
    task rdr(input [4:0] ra);
        frame(`PESR_OP_READ, phy_addr, ra, 16'hFFFF);
    endtask
    task pulse(input [7:0] v);
        event_pulse = v;
        @(negedge clk);
        event_pulse = 8'h00;
        repeat (3) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        rdr(`PESR_ADDR_EVENT);
        chk(rd, 16'h0000);
        rdr(`PESR_ADDR_CABLE);
        chk(rd, 16'h0000);
        rdr(`PESR_ADDR_LINE);
        chk(rd, 16'h0000);
        chk(16'(int_pin), 16'h0001);
        $display("test reset done");
    endtask
    // Masked event first, then the enabled one; flag writes must bounce
    task t_flags;
        integer j;
        int_active_high = 1'b1;
        repeat (3) @(negedge clk);
        for (j = 0; j < 8; j = j + 1) begin
            wr(`PESR_ADDR_EVENT, 16'h0100 << j);
            pulse(8'h01 << ((j + 1) % 8));
            chk(16'(int_pin), 16'h0000);
            pulse(8'h01 << j);
            chk(16'(int_pin), 16'h0001);
            wr(`PESR_ADDR_EVENT, (16'h0100 << j) | 16'h00FF);
            rdr(`PESR_ADDR_EVENT);
            chk(rd, (16'h0101 << j) | (16'h0001 << ((j + 1) % 8)));
            chk(16'(int_pin), 16'h0000);
            rdr(`PESR_ADDR_EVENT);
            chk(rd, 16'h0100 << j);
        end
        $display("test flags done");
    endtask
    task t_polarity;
        int_active_high = 1'b0;
        repeat (3) @(negedge clk);
        chk(16'(int_pin), 16'h0001);
        pulse(8'h80);
        chk(16'(int_pin), 16'h0000);
        int_active_high = 1'b1;
        repeat (3) @(negedge clk);
        chk(16'(int_pin), 16'h0001);
        int_active_high = 1'b0;
        rdr(`PESR_ADDR_EVENT);
        chk(rd, 16'h8080);
        chk(16'(int_pin), 16'h0001);
        wr(`PESR_ADDR_EVENT, 16'h0000);
        $display("test polarity done");
    endtask
    // Every outcome code; written result bits are read-only
    task t_cable;
        reg [1:0] r;
        integer n;
        for (n = 0; n < 4; n = n + 1) begin
            r = n[1:0];
            starts = 0;
            wr(`PESR_ADDR_CABLE, 16'hAA00);
            chk(16'(starts), 16'h0001);
            rdr(`PESR_ADDR_CABLE);
            chk(16'(rd[15]), 16'h0001);
            cable_test_result = r;
            cable_test_short = (r == 2'h2);
            cable_fault_dist = 9'h1FF - {7'h00, r};
            cable_test_done = 1'b1;
            @(negedge clk);
            cable_test_done = 1'b0;
            rdr(`PESR_ADDR_CABLE);
            chk(rd, {1'b0, r, r == 2'h2, 3'h5, 9'h1FF - {7'h00, r}});
        end
        $display("test cable done");
    endtask
    // Every mode code, status bits in counting patterns, then isolate
    task t_line;
        integer m;
        for (m = 0; m < 8; m = m + 1) begin
            op_mode = m[2:0];
            {flow_ctl_capable, link_is_up, polarity_reversed} = m[2:0];
            {mdix_state, energy_present} = ~m[1:0];
            rdr(`PESR_ADDR_LINE);
            chk(rd, {6'h00, m[2:0], 1'b0, ~m[1:0], 1'b0, m[2:0]});
        end
        wr(`PESR_ADDR_LINE, 16'hFFFF);
        chk(16'(isolate), 16'h0001);
        rdr(`PESR_ADDR_LINE);
        chk(rd, 16'h038F);
        frame(`PESR_OP_WRITE, phy_addr ^ 5'h01, `PESR_ADDR_LINE, 16'h0000);
        chk(16'(isolate), 16'h0001);
        wr(`PESR_ADDR_LINE, 16'h0000);
        chk(16'(isolate), 16'h0000);
        $display("test line done");
    endtask

    task give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard well past the expected run length
    initial begin
        #400000;
        bad_count = bad_count + 1;
        give_verdict;
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        t_reset;
        t_flags;
        t_polarity;
        t_cable;
        t_line;
        give_verdict;
    end
endmodule // tb
